// *** supply_supervisor_pkg.sv ***
// Overview of operation
// - A disabled low-side supervisor is off everywhere; enabled, it runs normal or full performance in active/LPM0/LPM1 per its full-performance bit.
// - In LOW_POWER_LEVEL_TWO/3/4 the low-side supervisor is off with mode 0, keeps its state under manual control, and drops full to normal and normal to off under automatic control.
// - The low-side monitor is off when disabled, follows its full-performance bit when awake, and in LOW_POWER_LEVEL_TWO/3/4 keeps its state (manual) or steps down one level (automatic).
// - Wake-up uses the slow time (about 150 us) only when the low-side supervisor is enabled in normal performance; otherwise the fast time.
// - The high-side supervisor decodes its enable, mode and full-performance bits exactly like the low side.
// - The high-side monitor is off when disabled, else normal or full when awake, and in LOW_POWER_LEVEL_TWO/3/4 keeps (manual) or steps down (automatic).
// - Entering LOW_POWER_LEVEL_TWO/3/4 while settling leaves the unit unable to wake; a power-up clear such as a watchdog one restores normal operation.
// - An external reset or a power cycle also recovers from the failed wake-up condition.
// - With overvoltage protection enabled, the high-side monitor raises a power-on reset when the supply exceeds its overvoltage threshold.
// - With high-side automatic control set, the high-side monitor raises no overvoltage reset in LOW_POWER_LEVEL_TWO/3/4, even when it steps down to normal there.
// Purpose: shared constants and decode functions of the supply supervisor
// Assumes: 200 MHz system clock, 32-bit AHB-Lite register bus
// Notes: unit states are 2-bit codes, off / normal / full performance
package supply_supervisor_pkg;
    localparam int CLOCK_MHZ = 200;
    localparam int SETTLE_FULL_NS = 2000;
    localparam int SETTLE_NORMAL_NS = 150000;
    localparam int WAKE_SLOW_NS = 150000;
    localparam int SETTLE_FULL_CYCLES = SETTLE_FULL_NS * CLOCK_MHZ / 1000;
    localparam int SETTLE_NORMAL_CYCLES = SETTLE_NORMAL_NS * CLOCK_MHZ / 1000;
    localparam int WAKE_SLOW_CYCLES = WAKE_SLOW_NS * CLOCK_MHZ / 1000;
    localparam int WAKE_FAST_CYCLES = 16;

    localparam logic [7:0] OFFSET_LOW_CTL = 8'h00;
    localparam logic [7:0] OFFSET_HIGH_CTL = 8'h04;
    localparam logic [7:0] OFFSET_FLAGS = 8'h08;
    localparam logic [7:0] OFFSET_INT_STATUS = 8'h0c;
    localparam logic [7:0] OFFSET_INT_MASK = 8'h10;
    localparam logic [7:0] OFFSET_UNIT_STATE = 8'h14;

    localparam int CTL_WIDTH = 7;
    localparam int BIT_SUP_EN = 0;
    localparam int BIT_SUP_MODE = 1;
    localparam int BIT_SUP_FP = 2;
    localparam int BIT_AUTO = 3;
    localparam int BIT_MON_EN = 4;
    localparam int BIT_MON_FP = 5;
    localparam int BIT_OVP_EN = 6;
    localparam logic [CTL_WIDTH-1:0] LOW_CTL_RESET = 7'h00;
    localparam logic [CTL_WIDTH-1:0] HIGH_CTL_RESET = 7'h00;

    localparam int INT_WIDTH = 4;
    localparam int INT_LOW_SETTLED = 0;
    localparam int INT_HIGH_SETTLED = 1;
    localparam int INT_WAKE_FAIL = 2;
    localparam int INT_WAKE_DONE = 3;
    localparam logic [INT_WIDTH-1:0] INT_MASK_RESET = 4'h0;

    localparam logic [1:0] UNIT_OFF = 2'h0;
    localparam logic [1:0] UNIT_NORMAL = 2'h1;
    localparam logic [1:0] UNIT_FULL = 2'h2;

    function automatic logic [1:0] supervisorState(input logic en,
        input logic md, input logic fp, input logic auto_, input logic deep);
        logic [1:0] awake;
        awake = fp ? UNIT_FULL : UNIT_NORMAL;
        if (!en) begin
            return UNIT_OFF;
        end else if (!deep) begin
            return awake;
        end else if (!md) begin
            return UNIT_OFF;
        end else if (!auto_) begin
            return awake;
        end
        return fp ? UNIT_NORMAL : UNIT_OFF;
    endfunction : supervisorState

    function automatic logic [1:0] monitorState(input logic en,
        input logic fp, input logic auto_, input logic deep);
        logic [1:0] awake;
        awake = fp ? UNIT_FULL : UNIT_NORMAL;
        if (!en) begin
            return UNIT_OFF;
        end else if (!deep || !auto_) begin
            return awake;
        end
        return fp ? UNIT_NORMAL : UNIT_OFF;
    endfunction : monitorState
endpackage : supply_supervisor_pkg

// *** interval_timer.sv ***
// Purpose: down counter that measures one settling or wake interval
// Assumes: load value of at least one cycle
// Notes: a load in the cycle the count ends restarts it and drops the done
`timescale 1ns/1ps
module interval_timer #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic clear,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic busy,
    output logic done
);
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic done_reg;
    logic done_next;

    initial begin
        if (WIDTH < 2 || WIDTH > 24) begin
            $error("interval_timer width out of range");
        end
    end

    assign count_next = load ? loadValue :
        (count_reg != '0) ? count_reg - 1'b1 : count_reg;
    assign done_next = !load && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});

    always_ff @(posedge clock) begin
        if (clear) begin
            count_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg <= done_next;
        end
    end

    assign busy = (count_reg != '0);
    assign done = done_reg;
endmodule : interval_timer

// *** supply_supervisor_mode_control.sv ***
// Purpose: supervisor and monitor mode decode, wake timing, settle flags
// Assumes: core gives one-cycle sleep entry and wake event pulses
// Notes: all reset sources clear the block synchronously, except the pin synchronisers, which only sys_rst clears
`timescale 1ns/1ps
module supply_supervisor_mode_control #(
    parameter int SETTLE_SLOW_CYCLES =
        supply_supervisor_pkg::SETTLE_NORMAL_CYCLES,
    parameter int WAKE_SLOW_CYCLES = supply_supervisor_pkg::WAKE_SLOW_CYCLES,
    parameter int WAKE_FAST_CYCLES = supply_supervisor_pkg::WAKE_FAST_CYCLES,
    parameter int TIMER_WIDTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic sleepEnter,
    input wire logic wakeEvent,
    input wire logic powerUpClear,
    input wire logic extReset_n,
    input wire logic overvoltageRaw,
    output logic [1:0] lowSupervisorState,
    output logic [1:0] lowMonitorState,
    output logic [1:0] highSupervisorState,
    output logic [1:0] highMonitorState,
    output logic slowWakeup,
    output logic inLowPower,
    output logic wakeDone,
    output logic wakeStuck,
    output logic porRequest,
    output logic irq
);
    typedef enum logic [1:0] {RUN, SLEEP, WAKING, STUCK} power_state_t;

    localparam int TW = TIMER_WIDTH;
    localparam int CW = supply_supervisor_pkg::CTL_WIDTH;
    localparam int IW = supply_supervisor_pkg::INT_WIDTH;

    initial begin
        if (SETTLE_SLOW_CYCLES < 1 || SETTLE_SLOW_CYCLES >= (1 << TW) ||
            WAKE_SLOW_CYCLES < 1 || WAKE_SLOW_CYCLES >= (1 << TW) ||
            WAKE_FAST_CYCLES < 1 || WAKE_FAST_CYCLES >= (1 << TW)) begin
            $error("interval counts do not fit the timer width");
        end
    end

    // pin synchronisers, reset only by the power cycle
    logic extMeta_reg;
    logic extSync_reg;
    logic ovMeta_reg;
    logic ovSync_reg;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            extMeta_reg <= 1'b1;
            extSync_reg <= 1'b1;
            ovMeta_reg <= 1'b0;
            ovSync_reg <= 1'b0;
        end else begin
            extMeta_reg <= extReset_n;
            extSync_reg <= extMeta_reg;
            ovMeta_reg <= overvoltageRaw;
            ovSync_reg <= ovMeta_reg;
        end
    end

    // any of these recovers a stuck wake-up, not only the power cycle
    logic clearAll;
    assign clearAll = sys_rst | powerUpClear | !extSync_reg;

    // bus address phase and data phase tracking
    logic addrTaken;
    logic wrPend_reg;
    logic wrPend_next;
    logic rdPend_reg;
    logic rdPend_next;
    logic rdDone_reg;
    logic rdDone_next;
    logic [7:0] phaseAddr_reg;
    logic [7:0] phaseAddr_next;

    assign addrTaken = hsel && htrans[1] && hready;
    assign wrPend_next = addrTaken && hwrite;
    assign rdPend_next = addrTaken ? !hwrite : (rdPend_reg && !rdDone_reg);
    assign rdDone_next = rdPend_reg && !rdDone_reg;
    assign phaseAddr_next = addrTaken ? haddr[7:0] : phaseAddr_reg;

    always_ff @(posedge clock) begin
        if (clearAll) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            rdDone_reg <= 1'b0;
            phaseAddr_reg <= 8'h00;
        end else begin
            wrPend_reg <= wrPend_next;
            rdPend_reg <= rdPend_next;
            rdDone_reg <= rdDone_next;
            phaseAddr_reg <= phaseAddr_next;
        end
    end

    // one wait state on reads so a write just before is already visible
    assign hreadyout = !(rdPend_reg && !rdDone_reg);
    assign hresp = 1'b0;

    logic wrLowCtl;
    logic wrHighCtl;
    logic wrIntStatus;
    logic wrIntMask;
    assign wrLowCtl = wrPend_reg &&
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_LOW_CTL);
    assign wrHighCtl = wrPend_reg &&
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_HIGH_CTL);
    assign wrIntStatus = wrPend_reg &&
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_INT_STATUS);
    assign wrIntMask = wrPend_reg &&
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_INT_MASK);

    // control registers
    logic [CW-1:0] lowCtl_reg;
    logic [CW-1:0] lowCtl_next;
    logic [CW-1:0] highCtl_reg;
    logic [CW-1:0] highCtl_next;
    assign lowCtl_next = wrLowCtl ? hwdata[CW-1:0] : lowCtl_reg;
    assign highCtl_next = wrHighCtl ? hwdata[CW-1:0] : highCtl_reg;

    always_ff @(posedge clock) begin
        if (clearAll) begin
            lowCtl_reg <= supply_supervisor_pkg::LOW_CTL_RESET;
            highCtl_reg <= supply_supervisor_pkg::HIGH_CTL_RESET;
        end else begin
            lowCtl_reg <= lowCtl_next;
            highCtl_reg <= highCtl_next;
        end
    end

    logic lowSupEn;
    logic lowSupMode;
    logic lowSupFp;
    logic lowAuto;
    logic lowMonEn;
    logic lowMonFp;
    logic highSupEn;
    logic highSupMode;
    logic highSupFp;
    logic highAuto;
    logic highMonEn;
    logic highMonFp;
    logic ovpEnable;
    assign lowSupEn = lowCtl_reg[supply_supervisor_pkg::BIT_SUP_EN];
    assign lowSupMode = lowCtl_reg[supply_supervisor_pkg::BIT_SUP_MODE];
    assign lowSupFp = lowCtl_reg[supply_supervisor_pkg::BIT_SUP_FP];
    assign lowAuto = lowCtl_reg[supply_supervisor_pkg::BIT_AUTO];
    assign lowMonEn = lowCtl_reg[supply_supervisor_pkg::BIT_MON_EN];
    assign lowMonFp = lowCtl_reg[supply_supervisor_pkg::BIT_MON_FP];
    assign highSupEn = highCtl_reg[supply_supervisor_pkg::BIT_SUP_EN];
    assign highSupMode = highCtl_reg[supply_supervisor_pkg::BIT_SUP_MODE];
    assign highSupFp = highCtl_reg[supply_supervisor_pkg::BIT_SUP_FP];
    assign highAuto = highCtl_reg[supply_supervisor_pkg::BIT_AUTO];
    assign highMonEn = highCtl_reg[supply_supervisor_pkg::BIT_MON_EN];
    assign highMonFp = highCtl_reg[supply_supervisor_pkg::BIT_MON_FP];
    assign ovpEnable = highCtl_reg[supply_supervisor_pkg::BIT_OVP_EN];

    // settle timers; a new write reloads, so the set wins over the expiry
    logic [TW-1:0] settleFull;
    logic [TW-1:0] settleSlow;
    logic [TW-1:0] lowSettleLoad;
    logic [TW-1:0] highSettleLoad;
    logic lowSettling;
    logic highSettling;
    logic lowSettled;
    logic highSettled;
    assign settleFull = TW'(supply_supervisor_pkg::SETTLE_FULL_CYCLES);
    assign settleSlow = TW'(SETTLE_SLOW_CYCLES);
    assign lowSettleLoad = hwdata[supply_supervisor_pkg::BIT_SUP_FP] ?
        settleFull : settleSlow;
    assign highSettleLoad = hwdata[supply_supervisor_pkg::BIT_SUP_FP] ?
        settleFull : settleSlow;

    interval_timer #(.WIDTH(TW)) lowSettleTimer (
        .clock(clock),
        .clear(clearAll),
        .load(wrLowCtl),
        .loadValue(lowSettleLoad),
        .busy(lowSettling),
        .done(lowSettled)
    );

    interval_timer #(.WIDTH(TW)) highSettleTimer (
        .clock(clock),
        .clear(clearAll),
        .load(wrHighCtl),
        .loadValue(highSettleLoad),
        .busy(highSettling),
        .done(highSettled)
    );

    // low-power sequencing
    power_state_t state_reg;
    power_state_t state_next;
    logic deep;
    logic wakeStart;
    logic wakeTimerDone;
    logic [TW-1:0] wakeLoad;
    logic enterStuck;

    assign deep = (state_reg != RUN);
    assign slowWakeup = lowSupEn && !lowSupFp;
    assign wakeLoad = slowWakeup ? TW'(WAKE_SLOW_CYCLES) :
        TW'(WAKE_FAST_CYCLES);
    assign wakeStart = (state_reg == SLEEP) && wakeEvent;
    // sleeping before both flags clear loses the wake path
    assign enterStuck = (state_reg == RUN) && sleepEnter &&
        (lowSettling || highSettling);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            RUN: begin
                if (sleepEnter) begin
                    state_next = enterStuck ? STUCK : SLEEP;
                end
            end
            SLEEP: begin
                if (wakeEvent) begin
                    state_next = WAKING;
                end
            end
            WAKING: begin
                if (wakeTimerDone) begin
                    state_next = RUN;
                end
            end
            STUCK: begin
                state_next = STUCK;
            end
            default: begin
                state_next = RUN;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (clearAll) begin
            state_reg <= RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    interval_timer #(.WIDTH(TW)) wakeTimer (
        .clock(clock),
        .clear(clearAll),
        .load(wakeStart),
        .loadValue(wakeLoad),
        .busy(),
        .done(wakeTimerDone)
    );

    // unit operating states
    logic [1:0] lowSupNext;
    logic [1:0] lowMonNext;
    logic [1:0] highSupNext;
    logic [1:0] highMonNext;
    logic [1:0] lowSup_reg;
    logic [1:0] lowMon_reg;
    logic [1:0] highSup_reg;
    logic [1:0] highMon_reg;
    assign lowSupNext = supply_supervisor_pkg::supervisorState(lowSupEn,
        lowSupMode, lowSupFp, lowAuto, deep);
    assign lowMonNext = supply_supervisor_pkg::monitorState(lowMonEn,
        lowMonFp, lowAuto, deep);
    assign highSupNext = supply_supervisor_pkg::supervisorState(highSupEn,
        highSupMode, highSupFp, highAuto, deep);
    assign highMonNext = supply_supervisor_pkg::monitorState(highMonEn,
        highMonFp, highAuto, deep);

    always_ff @(posedge clock) begin
        if (clearAll) begin
            lowSup_reg <= supply_supervisor_pkg::UNIT_OFF;
            lowMon_reg <= supply_supervisor_pkg::UNIT_OFF;
            highSup_reg <= supply_supervisor_pkg::UNIT_OFF;
            highMon_reg <= supply_supervisor_pkg::UNIT_OFF;
        end else begin
            lowSup_reg <= lowSupNext;
            lowMon_reg <= lowMonNext;
            highSup_reg <= highSupNext;
            highMon_reg <= highMonNext;
        end
    end

    // risky set-up for software to inspect; the hardware does not refuse it
    logic lowFastOrOff;
    logic highDropsOff;
    logic riskyConfig;
    assign lowFastOrOff = !lowSupEn || lowSupFp || !lowMonEn || lowMonFp;
    assign highDropsOff = (highSupEn && !highSupFp &&
        (!highSupMode || highAuto)) ||
        (highMonEn && !highMonFp && highAuto);
    assign riskyConfig = lowFastOrOff && highDropsOff;

    // overvoltage reset; auto control silences it while sleeping
    logic ovpActive;
    logic por_reg;
    logic por_next;
    assign ovpActive = ovpEnable && (highMonNext !=
        supply_supervisor_pkg::UNIT_OFF) && !(deep && highAuto);
    assign por_next = ovpActive && ovSync_reg;

    always_ff @(posedge clock) begin
        if (clearAll) begin
            por_reg <= 1'b0;
        end else begin
            por_reg <= por_next;
        end
    end

    // sticky interrupt flags, write one to clear, a new event wins
    logic [IW-1:0] events;
    logic [IW-1:0] intStatus_reg;
    logic [IW-1:0] intStatus_next;
    logic [IW-1:0] intMask_reg;
    logic [IW-1:0] intMask_next;
    logic [IW-1:0] statusClear;
    assign events = {wakeTimerDone, enterStuck, highSettled, lowSettled};
    assign statusClear = wrIntStatus ? hwdata[IW-1:0] : '0;
    assign intStatus_next = (intStatus_reg & ~statusClear) | events;
    assign intMask_next = wrIntMask ? hwdata[IW-1:0] : intMask_reg;

    always_ff @(posedge clock) begin
        if (clearAll) begin
            intStatus_reg <= '0;
            intMask_reg <= supply_supervisor_pkg::INT_MASK_RESET;
        end else begin
            intStatus_reg <= intStatus_next;
            intMask_reg <= intMask_next;
        end
    end

    assign irq = |(intStatus_reg & intMask_reg);

    // read data, captured in the wait cycle of a read
    logic [31:0] readWord;
    logic [31:0] unitWord;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    assign unitWord = {20'h00000, inLowPower, riskyConfig, wakeStuck,
        slowWakeup, highMon_reg, highSup_reg, lowMon_reg, lowSup_reg};
    assign readWord =
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_LOW_CTL) ?
            {{(32-CW){1'b0}}, lowCtl_reg} :
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_HIGH_CTL) ?
            {{(32-CW){1'b0}}, highCtl_reg} :
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_FLAGS) ?
            {30'h00000000, highSettling, lowSettling} :
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_INT_STATUS) ?
            {{(32-IW){1'b0}}, intStatus_reg} :
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_INT_MASK) ?
            {{(32-IW){1'b0}}, intMask_reg} :
        (phaseAddr_reg == supply_supervisor_pkg::OFFSET_UNIT_STATE) ?
            unitWord : 32'h00000000;
    assign hrdata_next = rdDone_next ? readWord : hrdata_reg;

    always_ff @(posedge clock) begin
        if (clearAll) begin
            hrdata_reg <= 32'h00000000;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata = hrdata_reg;
    assign lowSupervisorState = lowSup_reg;
    assign lowMonitorState = lowMon_reg;
    assign highSupervisorState = highSup_reg;
    assign highMonitorState = highMon_reg;
    assign inLowPower = deep;
    assign wakeDone = wakeTimerDone;
    assign wakeStuck = (state_reg == STUCK);
    assign porRequest = por_reg;
endmodule : supply_supervisor_mode_control

// *** supply_supervisor_assertions.sv ***
// Purpose: port checks of the supervisor mode control
// Assumes: one clock, synchronous active-high reset
// Notes: wake bounds allow a few cycles of slack on the pulse
`timescale 1ns/1ps
module supply_supervisor_checker #(
    parameter int WAKE_SLOW_CYCLES = 30,
    parameter int WAKE_FAST_CYCLES = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wakeEvent,
    input wire logic powerUpClear,
    input wire logic extReset_n,
    input wire logic overvoltageRaw,
    input wire logic [1:0] lowSupervisorState,
    input wire logic [1:0] highMonitorState,
    input wire logic slowWakeup,
    input wire logic inLowPower,
    input wire logic wakeDone,
    input wire logic wakeStuck,
    input wire logic porRequest,
    input wire logic irq
);
    localparam int SLOW_HI = WAKE_SLOW_CYCLES + 3;
    localparam int FAST_HI = WAKE_FAST_CYCLES + 3;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_awake_normal: assert property (
        (!inLowPower && slowWakeup)[*3] |-> lowSupervisorState == 2'h1)
        else $error("low supervisor not normal while awake");
    a_wake_slow: assert property (
        wakeEvent && inLowPower && !wakeStuck && slowWakeup
        |-> ##[WAKE_SLOW_CYCLES:SLOW_HI] wakeDone)
        else $error("slow wake interval wrong");
    a_wake_fast: assert property (
        wakeEvent && inLowPower && !wakeStuck && !slowWakeup
        |-> ##[WAKE_FAST_CYCLES:FAST_HI] wakeDone)
        else $error("fast wake interval wrong");
    a_wake_pulse: assert property (
        wakeDone |-> inLowPower ##1 (!inLowPower && !wakeDone))
        else $error("wake done pulse or exit wrong");
    // an external pin needs two sync edges, hence three quiet samples
    a_stuck_holds: assert property (
        wakeStuck && !powerUpClear && extReset_n && $past(extReset_n)
        && $past(extReset_n, 2) |=> wakeStuck)
        else $error("failed wake cleared without reset");
    a_clear_recovers: assert property (
        powerUpClear |=> !wakeStuck && !inLowPower && !porRequest
        && !irq && !slowWakeup && lowSupervisorState == 2'h0)
        else $error("clear left state");
    a_ext_recovers: assert property (
        !extReset_n [*3] |-> ##2 !wakeStuck && !inLowPower && !porRequest)
        else $error("ext reset no recovery");
    a_ovp_cause: assert property (
        $rose(porRequest) |-> $past(overvoltageRaw, 3))
        else $error("reset request without overvoltage");
    a_ovp_quiet: assert property (
        (inLowPower && highMonitorState == 2'h0)[*3] |-> !porRequest)
        else $error("reset request with monitor inactive");
endmodule : supply_supervisor_checker
bind supply_supervisor_mode_control supply_supervisor_checker #(
    .WAKE_SLOW_CYCLES(WAKE_SLOW_CYCLES),
    .WAKE_FAST_CYCLES(WAKE_FAST_CYCLES)
) supply_supervisor_checker_i (
    .clock, .sys_rst, .wakeEvent, .powerUpClear, .extReset_n,
    .overvoltageRaw, .lowSupervisorState, .highMonitorState,
    .slowWakeup, .inLowPower, .wakeDone, .wakeStuck, .porRequest, .irq
);

// *** tb_top.sv ***
// Purpose: self-checking bench of the supervisor mode control
// Assumes: short slow settle and wake counts set by parameters; the full settle keeps its package count of 400 cycles
// Notes: inputs change on the rising edge, outputs read on the falling
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [6:0] lo;
        logic [6:0] hi;
        logic [7:0] act;
        logic [7:0] lpm;
        logic slw;
    } row_t;
    // states packed as high mon, high sup, low mon, low sup
    localparam row_t ROWS [5] = '{
        '{7'h00, 7'h00, 8'h00, 8'h00, 1'b0},
        '{7'h11, 7'h37, 8'ha5, 8'ha4, 1'b1},
        '{7'h3f, 7'h1b, 8'h5a, 8'h05, 1'b0},
        '{7'h13, 7'h05, 8'h25, 8'h05, 1'b1},
        '{7'h1d, 7'h3e, 8'h86, 8'h40, 1'b0}};
    logic clock = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic sleepEnter = 1'b0, wakeEvent = 1'b0, powerUpClear = 1'b0;
    logic extReset_n = 1'b1, overvoltageRaw = 1'b0;
    logic hreadyout, hresp, slowWakeup, inLowPower, wakeDone;
    logic wakeStuck, porRequest, irq;
    logic [1:0] lowSupervisorState, lowMonitorState;
    logic [1:0] highSupervisorState, highMonitorState;
    wire logic hready = hreadyout;
    wire logic [7:0] st = {highMonitorState, highSupervisorState,
        lowMonitorState, lowSupervisorState};
    int mismatches = 0, checked = 0, n;
    always #2.5 clock = ~clock;
    supply_supervisor_mode_control #(
        .SETTLE_SLOW_CYCLES(20),
        .WAKE_SLOW_CYCLES(30),
        .WAKE_FAST_CYCLES(4)
    ) supply_supervisor_mode_control_i (
        .clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready, .hreadyout, .hrdata, .hresp, .sleepEnter,
        .wakeEvent, .powerUpClear, .extReset_n, .overvoltageRaw,
        .lowSupervisorState, .lowMonitorState, .highSupervisorState,
        .highMonitorState, .slowWakeup, .inLowPower, .wakeDone,
        .wakeStuck, .porRequest, .irq
    );
    task automatic chk(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input int d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic pulse(input logic w);
        @(posedge clock);
        if (w) wakeEvent <= 1'b1; else sleepEnter <= 1'b1;
        @(posedge clock);
        wakeEvent <= 1'b0;
        sleepEnter <= 1'b0;
    endtask : pulse
    task automatic final_report();
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk("reset states", {hresp, st}, 0);
        bus(1'b0, supply_supervisor_pkg::OFFSET_LOW_CTL, 0);
        chk("ctl reset", q, 0);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, supply_supervisor_pkg::OFFSET_LOW_CTL, ROWS[i].lo);
            bus(1'b1, supply_supervisor_pkg::OFFSET_HIGH_CTL, ROWS[i].hi);
            bus(1'b0, supply_supervisor_pkg::OFFSET_FLAGS, 0);
            chk("flags set", q, 3);
            n = 0;
            // flags must clear before sleeping or the wake is lost
            do begin
                bus(1'b0, supply_supervisor_pkg::OFFSET_FLAGS, 0);
                n++;
            end while (q !== 0 && n < 200);
            chk("flags clear", q, 0);
            bus(1'b0, supply_supervisor_pkg::OFFSET_UNIT_STATE, 0);
            chk("unit reg", q & 32'h1ff, {ROWS[i].slw, ROWS[i].act});
            @(negedge clock);
            chk("awake", st, ROWS[i].act);
            chk("slow", slowWakeup, ROWS[i].slw);
            pulse(1'b0);
            repeat (3) @(negedge clock);
            chk("asleep", st, ROWS[i].lpm);
            pulse(1'b1);
            for (n = 0; wakeDone !== 1'b1 && n < 100; n++) @(negedge clock);
            chk("woke", wakeDone, 1);
            repeat (3) @(negedge clock);
            chk("awake again", {inLowPower, st}, ROWS[i].act);
        end
        chk("irq masked", irq, 0);
        bus(1'b1, supply_supervisor_pkg::OFFSET_INT_MASK, 8);
        @(negedge clock);
        chk("irq on", irq, 1);
        bus(1'b1, supply_supervisor_pkg::OFFSET_INT_STATUS, 8);
        @(negedge clock);
        chk("irq off", irq, 0);
        bus(1'b0, supply_supervisor_pkg::OFFSET_INT_STATUS, 0);
        chk("status", q, 3);
        bus(1'b0, 8'h40, 0);
        chk("unmapped", q, 0);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, supply_supervisor_pkg::OFFSET_LOW_CTL, 1);
            pulse(1'b0);
            repeat (2) @(negedge clock);
            pulse(1'b1);
            repeat (60) @(negedge clock);
            chk("stuck", {wakeStuck, inLowPower}, 3);
            @(posedge clock);
            if (k == 0) powerUpClear <= 1'b1; else extReset_n <= 1'b0;
            repeat (4) @(negedge clock);
            chk("recovered", {wakeStuck, inLowPower}, 0);
            @(posedge clock);
            powerUpClear <= 1'b0;
            extReset_n <= 1'b1;
            repeat (4) @(negedge clock);
        end
        bus(1'b1, supply_supervisor_pkg::OFFSET_HIGH_CTL, 32'h50);
        repeat (30) @(negedge clock);
        @(posedge clock);
        overvoltageRaw <= 1'b1;
        repeat (4) @(negedge clock);
        chk("ovp", porRequest, 1);
        @(posedge clock);
        overvoltageRaw <= 1'b0;
        powerUpClear <= 1'b1;
        @(posedge clock);
        powerUpClear <= 1'b0;
        repeat (4) @(negedge clock);
        chk("ovp clear", porRequest, 0);
        bus(1'b1, supply_supervisor_pkg::OFFSET_HIGH_CTL, 32'h58);
        repeat (30) @(negedge clock);
        pulse(1'b0);
        @(posedge clock);
        overvoltageRaw <= 1'b1;
        repeat (6) @(negedge clock);
        chk("ovp asleep", porRequest, 0);
        @(posedge clock);
        sys_rst <= 1'b1;
        overvoltageRaw <= 1'b0;
        @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk("power cycle", {inLowPower, porRequest}, 0);
        final_report();
    end
endmodule : tb_top
